// File: logic/gmt_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the gated modulo timer.
 * Assumes a 100 MHz system clock and an 8-bit data register port.
 */
`ifndef GMT_DEFS_SVH
`define GMT_DEFS_SVH

`define GMT_ADDR_COMPARE 8'h1a
`define GMT_ADDR_COUNT 8'h1b
`define GMT_ADDR_CLKCTL 8'h2b
`define GMT_ADDR_MODE 8'h2c

`define GMT_CK_LO 0
`define GMT_CK_HI 1
`define GMT_CLR_BIT 2
`define GMT_EN_BIT 3
`define GMT_MD_BIT 0
`define GMT_GOEG_BIT 1
`define GMT_GCEG_BIT 2
`define GMT_OVF_BIT 3

`define GMT_COMPARE_RST 8'hff
`define GMT_COUNT_RST 8'h00
`define GMT_CTL_RST 4'h0

`define GMT_CLK_HZ 100000000
`define GMT_RATE0_HZ 100000
`define GMT_RATE1_HZ 10000
`define GMT_RATE2_HZ 2000
`define GMT_RATE3_HZ 1000
`define GMT_DIV0 (`GMT_CLK_HZ / `GMT_RATE0_HZ)
`define GMT_DIV1 (`GMT_CLK_HZ / `GMT_RATE1_HZ)
`define GMT_DIV2 (`GMT_CLK_HZ / `GMT_RATE2_HZ)
`define GMT_DIV3 (`GMT_CLK_HZ / `GMT_RATE3_HZ)

`endif

// File: logic/gmt_pkg.sv
/*
 * Types for the gated modulo timer.
 * Assumes nothing beyond the constants header.
 */
package gmt_pkg;

    // Gate state, one-hot.
    typedef enum logic [1:0] {
        GMT_GATE_SHUT = 2'b01,
        GMT_GATE_OPEN = 2'b10
    } gmt_gate_t;

endpackage : gmt_pkg

// File: logic/gmt_rate_gen.sv
/*
 * Basic clock generator: four free-running dividers, each giving a
 * one-cycle tick at its basic clock rate.
 * Assumes a single system clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "gmt_defs.svh"

module gmt_rate_gen
    import gmt_pkg::*;
#(
    parameter int DIV0 = `GMT_DIV0,
    parameter int DIV1 = `GMT_DIV1,
    parameter int DIV2 = `GMT_DIV2,
    parameter int DIV3 = `GMT_DIV3
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Ticks, one per rate.
    output logic [3:0] tick_o
);

    localparam int DIVS [4] = '{DIV0, DIV1, DIV2, DIV3};

    // Each divider runs on its own so a rate switch lands on a new edge.
    for (genvar g = 0; g < 4; g++) begin : g_div
        logic [16:0] cnt_r;
        logic [16:0] cnt_nxt;
        logic tick_r;
        logic tick_nxt;

        // Counts down and ticks on wrap.
        always_comb begin
            tick_nxt = (cnt_r == 17'h0);
            if (cnt_r == 17'h0) begin
                cnt_nxt = 17'(DIVS[g] - 1);
            end else begin
                cnt_nxt = cnt_r - 17'h1;
            end
        end

        // Registers the divider.
        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                cnt_r <= 17'h0;
                tick_r <= 1'b0;
            end else begin
                cnt_r <= cnt_nxt;
                tick_r <= tick_nxt;
            end
        end

        assign tick_o[g] = tick_r;
    end

endmodule : gmt_rate_gen

// File: logic/gmt_timer.sv
/*
 * Gated modulo timer: 8-bit counter with compare register, modulo and
 * external gate modes, overflow flag, interrupt request pulse.
 * Assumes registers are reached over a simple address/strobe data buffer
 * port, one access per cycle, and synchronous inputs.
 */
`timescale 1ns/1ps
`include "gmt_defs.svh"

module gmt_timer
    import gmt_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DIV0 = `GMT_DIV0,
    parameter int DIV1 = `GMT_DIV1,
    parameter int DIV2 = `GMT_DIV2,
    parameter int DIV3 = `GMT_DIV3
) (
    // Clock and resets.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_reset_i,
    // Data buffer register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // External gate input.
    input wire logic gate_input_pin_i,
    // Interrupt request and status.
    output logic irq_o,
    output logic [WIDTH-1:0] count_value_o
);

    logic [3:0] tick;
    logic [1:0] clock_select_r, clock_select_nxt;
    logic count_enable_r, count_enable_nxt;
    logic gate_mode_select_r, gate_mode_select_nxt;
    logic gate_open_edge_r, gate_open_edge_nxt;
    logic gate_close_edge_r, gate_close_edge_nxt;
    logic overflow_flag_r, overflow_flag_nxt;
    logic clear_pend_r, clear_pend_nxt;
    logic [WIDTH-1:0] compare_value_r, compare_value_nxt;
    logic [WIDTH-1:0] count_r, count_nxt;
    logic gate_in_r;
    gmt_gate_t gate_r, gate_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic base_tick, run, rise, fall, open_ev, close_ev;

    // Decodes an address against a register offset.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    gmt_rate_gen #(
        .DIV0(DIV0),
        .DIV1(DIV1),
        .DIV2(DIV2),
        .DIV3(DIV3)
    ) u_rate (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // Selected basic clock; a new selection waits for that clock's tick.
    assign base_tick = tick[clock_select_r];

    // Gate edges, judged against the previous sample of the pin.
    assign rise = gate_input_pin_i & ~gate_in_r;
    assign fall = ~gate_input_pin_i & gate_in_r;
    assign open_ev = gate_open_edge_r ? fall : rise;
    assign close_ev = gate_close_edge_r ? fall : rise;

    // Count permission: enable AND gate open in gate mode.
    assign run = count_enable_r &
        (~gate_mode_select_r | (gate_r == GMT_GATE_OPEN));

    // Next-state logic for registers, counter, gate and interrupt.
    always_comb begin
        clock_select_nxt = clock_select_r;
        count_enable_nxt = count_enable_r;
        gate_mode_select_nxt = gate_mode_select_r;
        gate_open_edge_nxt = gate_open_edge_r;
        gate_close_edge_nxt = gate_close_edge_r;
        overflow_flag_nxt = overflow_flag_r;
        clear_pend_nxt = clear_pend_r;
        compare_value_nxt = compare_value_r;
        count_nxt = count_r;
        gate_nxt = gate_r;
        irq_nxt = 1'b0;
        rdata_nxt = rdata_r;
        ack_nxt = reg_wr_i | reg_rd_i;

        // Gate state follows the configured open and close edges.
        case (gate_r)
            GMT_GATE_SHUT: begin
                if (gate_mode_select_r && open_ev) begin
                    gate_nxt = GMT_GATE_OPEN;
                end
            end
            GMT_GATE_OPEN: begin
                if (!gate_mode_select_r) begin
                    gate_nxt = GMT_GATE_SHUT;
                end else if (close_ev) begin
                    gate_nxt = GMT_GATE_SHUT;
                    irq_nxt = 1'b1;
                end
            end
            default: gate_nxt = GMT_GATE_SHUT;
        endcase

        // Counting happens only on a basic clock edge.
        if (base_tick) begin
            if (clear_pend_r) begin
                count_nxt = '0;
                clear_pend_nxt = 1'b0;
            end else if (run) begin
                if (!gate_mode_select_r &&
                    count_r == compare_value_r) begin
                    count_nxt = '0;
                    irq_nxt = 1'b1;
                end else if (count_r == {WIDTH{1'b1}}) begin
                    count_nxt = '0;
                    overflow_flag_nxt = 1'b1;
                    irq_nxt = 1'b1;
                end else begin
                    count_nxt = count_r + 1'b1;
                end
            end
        end

        // Register writes; the overflow set wins over a software clear only when overflow_flag_r was clear.
        if (reg_wr_i) begin
            if (hit(reg_addr_i, `GMT_ADDR_COMPARE)) begin
                compare_value_nxt = reg_wdata_i[WIDTH-1:0];
            end
            if (hit(reg_addr_i, `GMT_ADDR_CLKCTL)) begin
                clock_select_nxt = reg_wdata_i[`GMT_CK_HI:`GMT_CK_LO];
                count_enable_nxt = reg_wdata_i[`GMT_EN_BIT];
                if (reg_wdata_i[`GMT_CLR_BIT]) begin
                    clear_pend_nxt = 1'b1;
                end
            end
            if (hit(reg_addr_i, `GMT_ADDR_MODE)) begin
                gate_mode_select_nxt = reg_wdata_i[`GMT_MD_BIT];
                gate_open_edge_nxt = reg_wdata_i[`GMT_GOEG_BIT];
                gate_close_edge_nxt = reg_wdata_i[`GMT_GCEG_BIT];
                overflow_flag_nxt = reg_wdata_i[`GMT_OVF_BIT] |
                    (overflow_flag_nxt & ~overflow_flag_r);
            end
        end

        // Register reads; unmapped addresses read zero.
        if (reg_rd_i) begin
            if (hit(reg_addr_i, `GMT_ADDR_COMPARE)) begin
                rdata_nxt = compare_value_r;
            end else if (hit(reg_addr_i, `GMT_ADDR_COUNT)) begin
                rdata_nxt = count_r;
            end else if (hit(reg_addr_i, `GMT_ADDR_CLKCTL)) begin
                rdata_nxt = {4'h0, count_enable_r, 1'b0,
                    clock_select_r};
            end else if (hit(reg_addr_i, `GMT_ADDR_MODE)) begin
                rdata_nxt = {4'h0, overflow_flag_r, gate_close_edge_r,
                    gate_open_edge_r, gate_mode_select_r};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Registers all state; CE reset holds everything as it stands except irq_r and ack_r, which it clears.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clock_select_r <= 2'h0;
            count_enable_r <= 1'b0;
            gate_mode_select_r <= 1'b0;
            gate_open_edge_r <= 1'b0;
            gate_close_edge_r <= 1'b0;
            overflow_flag_r <= 1'b0;
            clear_pend_r <= 1'b0;
            compare_value_r <= `GMT_COMPARE_RST;
            count_r <= `GMT_COUNT_RST;
            gate_in_r <= 1'b0;
            gate_r <= GMT_GATE_SHUT;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
        end else if (!ce_reset_i) begin
            clock_select_r <= clock_select_nxt;
            count_enable_r <= count_enable_nxt;
            gate_mode_select_r <= gate_mode_select_nxt;
            gate_open_edge_r <= gate_open_edge_nxt;
            gate_close_edge_r <= gate_close_edge_nxt;
            overflow_flag_r <= overflow_flag_nxt;
            clear_pend_r <= clear_pend_nxt;
            compare_value_r <= compare_value_nxt;
            count_r <= count_nxt;
            gate_in_r <= gate_input_pin_i;
            gate_r <= gate_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end else begin
            irq_r <= 1'b0;
            ack_r <= 1'b0;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_ack_o = ack_r;
    assign irq_o = irq_r;
    assign count_value_o = count_r;

endmodule : gmt_timer

// File: tb/gmt_timer_checker.sv
/* Port assertions for the gated modulo timer.
   Bound to every gmt_timer instance; one clock domain. */
`timescale 1ns/1ps
module gmt_timer_checker #(
    parameter int WIDTH = 8
) (
    // Clock and resets.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_reset_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    // Gate, request and count.
    input wire logic gate_input_pin_i,
    input wire logic irq_o,
    input wire logic [WIDTH-1:0] count_value_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Register answers, count stepping, request causes and freezing.
    strobe_ack_a: assert property ((reg_rd_i || reg_wr_i) && !ce_reset_i
        |=> reg_ack_o) else $error("strobe not answered");
    count_read_a: assert property (reg_rd_i && !ce_reset_i &&
        reg_addr_i == 8'h1b |=> reg_rdata_o == $past(count_value_o))
        else $error("count read wrong");
    clear_read_a: assert property (reg_rd_i && !ce_reset_i &&
        reg_addr_i == 8'h2b |=> reg_rdata_o[2] == 1'b0)
        else $error("clear bit read as one");
    count_step_a: assert property ($changed(count_value_o) |->
        count_value_o == 0 || count_value_o == $past(count_value_o) + 1)
        else $error("count jumped");
    count_gap_a: assert property ($changed(count_value_o) |=>
        $stable(count_value_o) [*2]) else $error("count off tick");
    ce_freeze_a: assert property (ce_reset_i |=>
        $stable(count_value_o)) else $error("count moved in ce reset");
    ce_quiet_a: assert property (ce_reset_i [*2] |->
        !irq_o && !reg_ack_o) else $error("activity in ce reset");
    irq_cause_a: assert property (irq_o |-> count_value_o == 0 ||
        $past(gate_input_pin_i, 1) != $past(gate_input_pin_i, 2))
        else $error("request without cause");
    irq_pulse_a: assert property (irq_o |=> !irq_o)
        else $error("request longer than a cycle");
endmodule : gmt_timer_checker

bind gmt_timer gmt_timer_checker #(.WIDTH(WIDTH)) i_gmt_timer_checker (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_reset_i(ce_reset_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .gate_input_pin_i(gate_input_pin_i), .irq_o(irq_o),
    .count_value_o(count_value_o));

// File: tb/gmt_gate_src.sv
/* Pulse source for the external gate pin.
   Assumes one pulse is asked for at a time. */
`timescale 1ns/1ps
module gmt_gate_src (
    // Clock.
    input wire logic clk_sys_i,
    // Pulse request, width in cycles, idle level.
    input wire logic go_i,
    input wire logic [15:0] width_i,
    input wire logic idle_i,
    // Gate pin.
    output logic pin_o
);
    logic [15:0] left_r = 16'h0000;
    // Counts the pulse down; pulse edges on the pin come only after a rising edge, an idle_i change acts at once.
    always_ff @(posedge clk_sys_i) begin
        left_r <= go_i ? width_i : left_r - (left_r != 16'h0000);
    end
    assign pin_o = idle_i ^ (left_r != 16'h0000);
endmodule : gmt_gate_src

// File: tb/gmt_timer_bench.sv
/* Bench for the gated modulo timer: register calls and gate pulses.
   Assumes dividers shortened to 4, 6, 8 and 10 cycles. */
`timescale 1ns/1ps
module gmt_timer_bench;
    logic clk_sys_i = 0, rst_i = 1, ce = 0, wr = 0, rd = 0, go = 0;
    logic idle = 0, ack, irq, pin;
    logic [7:0] addr = 0, wd = 0, rdat, cnt, v;
    logic [15:0] width = 0;
    logic [7:0] ra[5] = '{8'h1a, 8'h1b, 8'h2b, 8'h2c, 8'h30};
    logic [7:0] rv[5] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    int err_count = 0, n_tests = 0, cyc = 0, n;
    gmt_timer #(.DIV0(4), .DIV1(6), .DIV2(8), .DIV3(10)) i_gmt_timer (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_reset_i(ce),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .reg_ack_o(ack), .gate_input_pin_i(pin),
        .irq_o(irq), .count_value_o(cnt));
    gmt_gate_src i_gmt_gate_src (.clk_sys_i(clk_sys_i), .go_i(go),
        .width_i(width), .idle_i(idle), .pin_o(pin));
    // Clock of 10 ns and a cycle ceiling against hangs.
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // One register access; read data lands in v.
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge clk_sys_i);
        {wr, rd, addr, wd} = {w, !w, a, d};
        @(negedge clk_sys_i);
        {wr, rd} = 2'b00;
        v = rdat;
        chk(ack, 1'b1);
    endtask : acc
    task automatic wirq(input int lim);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask : wirq
    task automatic pulse(input logic [15:0] w);
        width = w;
        go = 1;
        @(negedge clk_sys_i);
        go = 0;
    endtask : pulse
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    // Main sequence of tests.
    initial begin
        repeat (6) @(negedge clk_sys_i);
        rst_i = 0;
        for (int i = 0; i < 5; i++) begin
            acc(0, ra[i], 8'h00);
            chk(v, rv[i]);
        end
        acc(1, 8'h1a, 8'h03);
        acc(0, 8'h1a, 8'h00);
        chk(v, 8'h03);
        acc(1, 8'h1b, 8'h55);
        acc(0, 8'h1b, 8'h00);
        chk(v, 8'h00);
        $display("Test registers done");
        for (int k = 0; k < 4; k++) begin
            acc(1, 8'h2b, 8'h04);
            repeat (12) @(negedge clk_sys_i);
            acc(1, 8'h2b, 8'h0c | 8'(k));
            acc(0, 8'h2b, 8'h00);
            chk(v, 8'h08 | 8'(k));
            wirq(200);
            chk(cnt, 8'h00);
            wirq(200);
            chk(n, 4 * (4 + 2 * k));
        end
        $display("Test modulo done");
        acc(1, 8'h1a, 8'h01);
        for (int k = 0; k < 2; k++) begin
            acc(1, 8'h2c, k ? 8'h03 : 8'h05);
            idle = k[0];
            acc(1, 8'h2b, 8'h0c);
            repeat (12) @(negedge clk_sys_i);
            pulse(40);
            wirq(60);
            chk(n >= 38 && n <= 46, 1'b1);
            chk(cnt >= 9 && cnt <= 11, 1'b1);
            acc(0, 8'h1b, 8'h00);
            repeat (12) @(negedge clk_sys_i);
            chk(cnt, v);
            acc(1, 8'h2b, 8'h04);
            repeat (12) @(negedge clk_sys_i);
            chk(cnt, 8'h00);
        end
        $display("Test gate done");
        acc(1, 8'h2c, 8'h05);
        idle = 0;
        repeat (12) @(negedge clk_sys_i);
        acc(1, 8'h2b, 8'h08);
        pulse(1100);
        wirq(1100);
        chk(cnt, 8'h00);
        acc(0, 8'h2c, 8'h00);
        chk(v, 8'h0d);
        acc(1, 8'h2c, 8'h05);
        acc(0, 8'h2c, 8'h00);
        chk(v, 8'h05);
        wirq(200);
        $display("Test overflow done");
        acc(1, 8'h2c, 8'h00);
        repeat (20) @(negedge clk_sys_i);
        ce = 1;
        v = cnt;
        repeat (30) @(negedge clk_sys_i);
        chk(cnt, v);
        ce = 0;
        $display("Test ce reset done");
        summarize();
    end
endmodule : gmt_timer_bench
